// ### rtl/etc_consts.svh
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define ETC_NUM_IN      16
`define ETC_IDX_W       4
`define ETC_QDEPTH      160
`define ETC_QCW         8
`define ETC_EVW         16
`define ETC_STW         64
`define ETC_ARM_LEN     5

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ETC_ADDR_CTRL   12'h000
`define ETC_ADDR_CAPEN  12'h004
`define ETC_ADDR_ACKSEL 12'h008
`define ETC_ADDR_STROBE 12'h00C
`define ETC_ADDR_ECHO   12'h010
`define ETC_ADDR_FLAGS  12'h014
`define ETC_ADDR_EVCNT  12'h018
`define ETC_ADDR_QSTAT  12'h01C
`define ETC_ADDR_HINFO  12'h020
`define ETC_ADDR_HLO    12'h024
`define ETC_ADDR_HHI    12'h028
`define ETC_STAMP_PAGE  4'h1

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ETC_CTRL_QUEUE  0
`define ETC_CTRL_LATCH  1
`define ETC_CTRL_RST    2'h2
`define ETC_CAPEN_RST   32'hFFFFFFFF
`define ETC_STRB_CLR    16
`define ETC_ACK_FALL    2'h0
`define ETC_ACK_RISE    2'h1
`define ETC_ACK_BOTH    2'h2

`endif

// ### rtl/etc_pkg.sv
`include "etc_consts.svh"

package etc_pkg;
   typedef struct packed {
      logic [`ETC_IDX_W-1:0] idx;
      logic                  rise;
      logic [`ETC_EVW-1:0]   evnum;
      logic [`ETC_STW-1:0]   stamp;
   } etc_entry_t;
endpackage

// ### rtl/etc_queue.sv
`include "etc_consts.svh"

module etc_queue #(
   parameter int DEPTH = `ETC_QDEPTH
) (
   // Clock and reset
   input wire logic  core_clk_i,
   input wire logic  nrst_i,
   // Queue port
   etc_queue_if.fifo q
);
   import etc_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   etc_entry_t        mem [DEPTH];
   logic [AW-1:0]     wr_r;
   logic [AW-1:0]     rd_r;
   logic [CW-1:0]     cnt_r;
   logic              push;
   logic              pop;

   assign push         = q.push_valid & q.push_ready & ~q.flush;
   assign pop          = q.pop & q.head_valid & ~q.flush;
   assign q.push_ready = (cnt_r < CW'(DEPTH)); // [R18]
   assign q.head_valid = (cnt_r != '0);
   assign q.head       = mem[rd_r]; // [R13]
   assign q.count      = `ETC_QCW'(cnt_r);

   // Entries need no reset; only the pointers and the count define what is held
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_r] <= q.push_data; // [R12]
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || q.flush) begin // [R7]
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1; // [R16]
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || q.flush) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end

   AST_Q_NO_OVERFILL: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R18]
      cnt_r <= CW'(DEPTH)) else $error("queue holds more entries than its depth");
   AST_Q_FLUSH: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R7]
      q.flush |=> (cnt_r == '0)) else $error("queue not empty after flush");

endmodule // etc_queue

// ### rtl/etc_queue_if.sv
`include "etc_consts.svh"

interface etc_queue_if #(parameter int CW = `ETC_QCW);
   import etc_pkg::*;
   logic              push_valid;
   logic              push_ready;
   etc_entry_t        push_data;
   logic              head_valid;
   etc_entry_t        head;
   logic              pop;
   logic              flush;
   logic [CW-1:0]     count;
   modport fifo (input push_valid, push_data, pop, flush,
                 output push_ready, head_valid, head, count);
   modport user (output push_valid, push_data, pop, flush,
                 input push_ready, head_valid, head, count);
endinterface

// ### rtl/etc_top.sv
`include "etc_consts.svh"

// Overview of operation
// [R1] Latched stamp blocks same-direction repeats until acknowledged
// [R2] Ack select: 0 fall, 1 rise, 2 both
// [R3] Acknowledge acts only on ack strobe rising
// [R4] Controller lowers strobe one interval before re-raising
// [R5] Acknowledge also clears overflow and new-data flags
// [R6] Cleared direction stamps its next transition again
// [R7] Clear-all strobe rising erases everything, queue included
// [R8] After clear-all every produced word reads zero
// [R9] After clear-all stamp only enabled directions
// [R10] Without latching, newest transition overwrites the stamp
// [R11] Queue mode stamps enabled inputs, many each
// [R12] Queue stores events in arrival order
// [R13] Oldest queued event is the current event
// [R14] Current event is produced until cleared
// [R15] Controller echoes event count to acknowledge
// [R16] Clearing current event advances to next one
// [R17] Transitions far enough apart get distinct stamps
// [R18] Queue accepts events only below its depth
// [R19] Running event count increments per stamp
// [R20] Dropped latched transition sets overflow flag
// [R21] Full queue: skip transition, set overflow
// [R22] Per-input rise and fall stamps, 64 bits
// [R23] Strobe edges found against previously held value
module etc_top #(
   parameter int DEPTH = `ETC_QDEPTH
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Digital inputs
   input  wire logic [15:0] din_i
);
   import etc_pkg::*;

   localparam int NIN = `ETC_NUM_IN;

   logic [NIN-1:0]          s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
   logic [`ETC_ARM_LEN-1:0] arm_r;
   logic [NIN-1:0]          rise_ev, fall_ev;
   logic [1:0]              ctrl_r;
   logic [31:0]             capen_r, acksel_r;
   logic [16:0]             strb_r, strb_prev_r;
   logic [`ETC_EVW-1:0]     echo_r, evcnt_r;
   logic [`ETC_STW-1:0]     stamp_r;
   logic [NIN-1:0]          rise_vld_r, fall_vld_r, nd_r, ovf_r;
   logic [2*NIN-1:0]        pend_r, qnew, gnt, served;
   logic [4:0]              gidx;
   logic [NIN-1:0]          ack_hit, clr_rise, clr_fall, q_ovf;
   logic [NIN-1:0]          rise_hit, fall_hit, rise_take, fall_take, rise_lost, fall_lost;
   logic [`ETC_STW-1:0]     rise_st [NIN];
   logic [`ETC_STW-1:0]     fall_st [NIN];
   logic                    pm, qm, latch, clr_all, acc, wr_en, push_fire, wr_echo;
   logic                    full_drop;
   logic [31:0]             rd_nxt;
   logic                    bad_nxt;

   etc_queue_if #(.CW(`ETC_QCW)) qif ();

   etc_queue #(.DEPTH(DEPTH)) u_queue (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .q          (qif.fifo)
   );

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A level counts once stages two and three agree
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         lvl_r   <= '0;
         lvl_d_r <= '0;
      end else begin
         lvl_r   <= (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
         lvl_d_r <= lvl_r;
      end
   end

   // Edges are held off until the pipe has filled, so a pin high at reset is no event
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         arm_r <= '0;
      end else begin
         arm_r <= {arm_r[`ETC_ARM_LEN-2:0], 1'b1};
      end
   end

   assign rise_ev = lvl_r & ~lvl_d_r & {NIN{arm_r[`ETC_ARM_LEN-1]}};
   assign fall_ev = ~lvl_r & lvl_d_r & {NIN{arm_r[`ETC_ARM_LEN-1]}};

   // ----------------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------------
   // One tick per clock, so any two cycles apart already differ
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         stamp_r <= '0;
      end else begin
         stamp_r <= stamp_r + 1'b1; // [R17]
      end
   end

   // ----------------------------------------------------------------------
   // APB slave and control registers
   // ----------------------------------------------------------------------
   assign acc   = psel_i & penable_i;
   assign wr_en = acc & pwrite_i & pready_o;
   assign pm    = ~ctrl_r[`ETC_CTRL_QUEUE];
   assign qm    = ctrl_r[`ETC_CTRL_QUEUE];
   assign latch = ctrl_r[`ETC_CTRL_LATCH];

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end else begin
         pready_o  <= acc & ~pready_o;
         pslverr_o <= acc & ~pready_o & bad_nxt;
         if (acc && !pready_o && !pwrite_i) begin
            prdata_o <= rd_nxt;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ctrl_r   <= `ETC_CTRL_RST;
         capen_r  <= `ETC_CAPEN_RST;
         acksel_r <= '0;
         strb_r   <= '0;
         echo_r   <= '0;
      end else if (wr_en) begin
         if (paddr_i == `ETC_ADDR_CTRL) begin
            ctrl_r <= pwdata_i[1:0];
         end else if (paddr_i == `ETC_ADDR_CAPEN) begin
            capen_r <= pwdata_i;
         end else if (paddr_i == `ETC_ADDR_ACKSEL) begin
            acksel_r <= pwdata_i;
         end else if (paddr_i == `ETC_ADDR_STROBE) begin
            strb_r <= pwdata_i[16:0];
         end else if (paddr_i == `ETC_ADDR_ECHO) begin
            echo_r <= pwdata_i[`ETC_EVW-1:0];
         end
      end
   end

   // Held copy of the last strobe word; a rise against it is the command
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         strb_prev_r <= '0;
      end else begin
         strb_prev_r <= strb_r; // [R23]
      end
   end

   assign ack_hit = strb_r[NIN-1:0] & ~strb_prev_r[NIN-1:0]; // [R3] [R4]
   assign clr_all = strb_r[`ETC_STRB_CLR] & ~strb_prev_r[`ETC_STRB_CLR]; // [R7]

   // ----------------------------------------------------------------------
   // Per-input capture
   // ----------------------------------------------------------------------
   assign rise_hit  = rise_ev & capen_r[NIN-1:0] & {NIN{pm}}; // [R9]
   assign fall_hit  = fall_ev & capen_r[2*NIN-1:NIN] & {NIN{pm}};
   assign rise_lost = rise_hit & rise_vld_r & ~clr_rise; // [R20]
   assign fall_lost = fall_hit & fall_vld_r & ~clr_fall;
   assign rise_take = rise_hit & ~(rise_lost & {NIN{latch}}); // [R1] [R6] [R10]
   assign fall_take = fall_hit & ~(fall_lost & {NIN{latch}});

   for (genvar i = 0; i < NIN; i++) begin : g_in
      logic [`ETC_STW-1:0] rst_r, fst_r;
      logic [1:0]          sel;
      assign sel         = acksel_r[2*i +: 2];
      assign clr_rise[i] = clr_all | (ack_hit[i] & ((sel == `ETC_ACK_RISE) ||
                           (sel == `ETC_ACK_BOTH))); // [R2]
      assign clr_fall[i] = clr_all | (ack_hit[i] & ((sel == `ETC_ACK_FALL) ||
                           (sel == `ETC_ACK_BOTH)));
      assign q_ovf[i]    = served[2*i] | served[2*i+1] ? 1'b0 : (qnew[2*i] & pend_r[2*i]) |
                           (qnew[2*i+1] & pend_r[2*i+1]);
      assign rise_st[i]  = rst_r;
      assign fall_st[i]  = fst_r;

      // A new stamp in the clearing cycle survives the clear
      always_ff @(posedge core_clk_i) begin
         if (!nrst_i) begin
            rst_r <= '0;
         end else if (rise_take[i]) begin
            rst_r <= stamp_r; // [R22]
         end else if (clr_rise[i]) begin
            rst_r <= '0; // [R5]
         end
      end

      always_ff @(posedge core_clk_i) begin
         if (!nrst_i) begin
            fst_r <= '0;
         end else if (fall_take[i]) begin
            fst_r <= stamp_r;
         end else if (clr_fall[i]) begin
            fst_r <= '0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rise_vld_r <= '0;
         fall_vld_r <= '0;
      end else begin
         rise_vld_r <= (rise_vld_r & ~clr_rise) | rise_take; // [R6]
         fall_vld_r <= (fall_vld_r & ~clr_fall) | fall_take;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         nd_r  <= '0;
         ovf_r <= '0;
      end else begin
         nd_r  <= (nd_r & ~ack_hit & ~{NIN{clr_all}}) | rise_take | fall_take; // [R5]
         ovf_r <= (ovf_r & ~ack_hit & ~{NIN{clr_all}}) | rise_lost | fall_lost | q_ovf |
                  (full_drop ? NIN'(1) << gidx[4:1] : '0); // [R20] [R21]
      end
   end

   // ----------------------------------------------------------------------
   // Queue feed: one pending event enters per cycle, lowest index first
   // ----------------------------------------------------------------------
   // Stamping at entry lags the transition by one cycle or more, one more per lower-index event still pending
   always_comb begin
      qnew = '0;
      for (int k = 0; k < NIN; k++) begin
         qnew[2*k]   = qm & rise_ev[k] & capen_r[k]; // [R11]
         qnew[2*k+1] = qm & fall_ev[k] & capen_r[NIN+k];
      end
   end

   always_comb begin
      gnt  = '0;
      gidx = '0;
      for (int k = 2*NIN-1; k >= 0; k--) begin
         if (pend_r[k]) begin
            gnt     = '0;
            gnt[k]  = 1'b1;
            gidx    = 5'(k);
         end
      end
   end

   assign qif.push_valid = qm & (|pend_r) & ~clr_all;
   assign qif.push_data  = {gidx[4:1], ~gidx[0], `ETC_EVW'(evcnt_r + 1'b1), stamp_r};
   assign served         = qif.push_valid ? gnt : '0;
   assign push_fire      = qif.push_valid & qif.push_ready; // [R12]
   assign full_drop      = qif.push_valid & ~qif.push_ready; // [R18] [R21]
   assign qif.flush      = clr_all;
   assign wr_echo        = wr_en & (paddr_i == `ETC_ADDR_ECHO);
   assign qif.pop        = wr_echo & qm & qif.head_valid & ~clr_all &
                           (pwdata_i[`ETC_EVW-1:0] == qif.head.evnum); // [R15] [R16]

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pend_r <= '0;
      end else begin
         pend_r <= (clr_all ? '0 : (pend_r & ~served)) | qnew;
      end
   end

   // ----------------------------------------------------------------------
   // Event count
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         evcnt_r <= '0;
      end else begin
         evcnt_r <= (clr_all ? '0 : evcnt_r) + `ETC_EVW'($countones({rise_take, fall_take})) +
                    `ETC_EVW'(push_fire); // [R19] [R8]
      end
   end

   // ----------------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------------
   always_comb begin
      rd_nxt  = '0;
      bad_nxt = 1'b0;
      if (paddr_i == `ETC_ADDR_CTRL) begin
         rd_nxt = {30'h0, ctrl_r};
      end else if (paddr_i == `ETC_ADDR_CAPEN) begin
         rd_nxt = capen_r;
      end else if (paddr_i == `ETC_ADDR_ACKSEL) begin
         rd_nxt = acksel_r;
      end else if (paddr_i == `ETC_ADDR_STROBE) begin
         rd_nxt = {15'h0, strb_r};
      end else if (paddr_i == `ETC_ADDR_ECHO) begin
         rd_nxt = {16'h0, echo_r};
      end else if (paddr_i == `ETC_ADDR_FLAGS) begin
         rd_nxt = {ovf_r, nd_r};
      end else if (paddr_i == `ETC_ADDR_EVCNT) begin
         rd_nxt = {16'h0, evcnt_r};
      end else if (paddr_i == `ETC_ADDR_QSTAT) begin
         rd_nxt = {23'h0, qif.head_valid, qif.count};
      end else if (paddr_i == `ETC_ADDR_HINFO) begin
         rd_nxt = qif.head_valid ? {qif.head.evnum, 11'h0, qif.head.rise, qif.head.idx} : '0;
      end else if (paddr_i == `ETC_ADDR_HLO) begin
         rd_nxt = qif.head_valid ? qif.head.stamp[31:0] : '0; // [R14]
      end else if (paddr_i == `ETC_ADDR_HHI) begin
         rd_nxt = qif.head_valid ? qif.head.stamp[63:32] : '0;
      end else if (paddr_i[11:8] == `ETC_STAMP_PAGE) begin
         if (paddr_i[3:2] == 2'h0) begin
            rd_nxt = rise_st[paddr_i[7:4]][31:0];
         end else if (paddr_i[3:2] == 2'h1) begin
            rd_nxt = rise_st[paddr_i[7:4]][63:32];
         end else if (paddr_i[3:2] == 2'h2) begin
            rd_nxt = fall_st[paddr_i[7:4]][31:0];
         end else begin
            rd_nxt = fall_st[paddr_i[7:4]][63:32];
         end
      end else begin
         bad_nxt = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_echo_match;
      qif.pop && !push_fire;
   endsequence

   sequence s_two_pushes;
      push_fire ##1 push_fire;
   endsequence

   AST_LATCH_HOLD: assert property ( // [R1]
      (latch && rise_vld_r[0] && !clr_rise[0]) |=> $stable(rise_st[0]))
      else $error("latched rise stamp changed without acknowledge");
   AST_ACK_BOTH: assert property ( // [R2]
      (ack_hit[0] && acksel_r[1:0] == `ETC_ACK_BOTH && !rise_ev[0] && !fall_ev[0])
      |=> (!rise_vld_r[0] && !fall_vld_r[0] && rise_st[0] == '0))
      else $error("select two did not clear both stamps");
   AST_ACK_FALL_ONLY: assert property ( // [R2]
      (ack_hit[0] && acksel_r[1:0] == `ETC_ACK_FALL && !clr_all && rise_vld_r[0])
      |=> rise_vld_r[0]) else $error("select zero cleared the rise stamp");
   AST_ACK_LEVEL: assert property ( // [R3]
      (!ack_hit[0] && !clr_all && fall_vld_r[0]) |=> fall_vld_r[0])
      else $error("stamp cleared without a strobe rise");
   AST_ACK_FLAGS: assert property ( // [R5]
      (ack_hit[0] && !rise_ev[0] && !fall_ev[0] && !qm) |=> (!nd_r[0] && !ovf_r[0]))
      else $error("acknowledge left flags set");
   AST_CLEAR_ALL: assert property ( // [R7]
      (clr_all && rise_ev == '0 && fall_ev == '0)
      |=> (evcnt_r == '0 && rise_vld_r == '0 && fall_vld_r == '0 && qif.count == '0
           && ovf_r == '0 && nd_r == '0)) else $error("clear-all left data behind");
   AST_NOLATCH_OVERWRITE: assert property ( // [R10]
      (!latch && rise_hit[0]) |=> (rise_st[0] == $past(stamp_r)))
      else $error("unlatched transition did not overwrite stamp");
   AST_QUEUE_ENABLE: assert property ( // [R11]
      (qm && !capen_r[0] && !pend_r[0]) |=> !pend_r[0])
      else $error("disabled input entered the queue");
   AST_POP_ADVANCE: assert property ( // [R16]
      s_echo_match |=> (qif.count == $past(qif.count) - 1'b1))
      else $error("matching echo did not advance the queue");
   AST_DISTINCT: assert property ( // [R17]
      s_two_pushes |-> (qif.push_data.stamp != $past(qif.push_data.stamp)))
      else $error("two events share a stamp");
   AST_EVCNT_STEP: assert property ( // [R19]
      (push_fire && !clr_all) |=> (evcnt_r == $past(evcnt_r) + 1'b1))
      else $error("event count did not step on a stored event");
   AST_FULL_OVERFLOW: assert property ( // [R21]
      (full_drop && !qif.pop) |=> (qif.count == $past(qif.count) && ovf_r[$past(gidx[4:1])]))
      else $error("full queue changed or did not flag overflow");

endmodule // etc_top

// ### verification/etc_ctrl_model.sv
`include "etc_consts.svh"

module etc_ctrl_model (
   // Clock
   input  wire logic        core_clk_i,
   // APB master side
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [11:0] paddr_o,
   output logic      [31:0] pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Transfers
   // ----
   initial begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 12'h000;
      pwdata_o  = 32'h0;
   end
   // Request stays put until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      @(posedge core_clk_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= w;
      paddr_o   <= a;
      pwdata_o  <= d;
      @(posedge core_clk_i);
      penable_o <= 1'b1;
      do @(posedge core_clk_i); while (pready_i !== 1'b1);
      r = prdata_i;
      e = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
   endtask
   // Held low past one update so the next raise is a fresh edge
   task automatic strobe(input logic [31:0] m);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, `ETC_ADDR_STROBE, m, r, e);
      xfer(1'b1, `ETC_ADDR_STROBE, 32'h0, r, e);
      repeat (4) @(posedge core_clk_i);
   endtask
   // Echo the head event number to retire it
   task automatic pop();
      logic [31:0] r;
      logic        e;
      xfer(1'b0, `ETC_ADDR_HINFO, 32'h0, r, e);
      xfer(1'b1, `ETC_ADDR_ECHO, {16'h0, r[31:16]}, r, e);
   endtask
endmodule // etc_ctrl_model

// ### verification/tb.sv
`include "etc_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Bench
   // ----
   logic        core_clk_i;
   logic        nrst_i;
   logic        psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, s, a, b;
   logic [15:0] din;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          cyc = 0;

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // Small depth so the full case is cheap to reach
   etc_top #(.DEPTH(4)) u_etc_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .din_i(din));
   etc_ctrl_model ctrl (.core_clk_i(core_clk_i), .psel_o(psel),
      .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
      .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr));

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
         n_mismatch++;
      end
   endtask
   task automatic get(input logic [11:0] ad);
      ctrl.xfer(1'b0, ad, 32'h0, r, e);
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] x);
      get(ad);
      cmp(r, x);
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      ctrl.xfer(1'b1, ad, d, s, e);
   endtask
   // Ten clocks cover the synchroniser and edge pipeline
   task automatic pin(input int i, input logic v);
      @(posedge core_clk_i);
      din[i] <= v;
      repeat (10) @(posedge core_clk_i);
   endtask

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      nrst_i = 1'b0;
      din    = 16'h0;
      repeat (12) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      rd(`ETC_ADDR_CTRL, 32'h2);
      rd(`ETC_ADDR_CAPEN, 32'hFFFFFFFF);
      get(12'h0FC);
      cmp({31'h0, e}, 32'h1);
      $display("reset test done");
      pin(0, 1'b1);
      pin(0, 1'b0);
      get(12'h100);
      a = r;
      get(12'h108);
      b = r;
      cmp({31'h0, a != b && a != 0}, 32'h1);
      rd(12'h104, 32'h0);
      rd(12'h10C, 32'h0);
      pin(0, 1'b1);
      rd(12'h100, a);
      rd(`ETC_ADDR_FLAGS, 32'h00010001);
      rd(`ETC_ADDR_EVCNT, 32'h2);
      wr(`ETC_ADDR_ACKSEL, 32'h1);
      ctrl.strobe(32'h1);
      rd(12'h100, 32'h0);
      rd(12'h108, b);
      rd(`ETC_ADDR_FLAGS, 32'h0);
      pin(0, 1'b0);
      pin(0, 1'b1);
      get(12'h100);
      a = r;
      cmp({31'h0, a != 0}, 32'h1);
      wr(`ETC_ADDR_ACKSEL, 32'h0);
      ctrl.strobe(32'h1);
      rd(12'h100, a);
      rd(12'h108, 32'h0);
      pin(0, 1'b0);
      wr(`ETC_ADDR_ACKSEL, 32'h2);
      ctrl.strobe(32'h1);
      rd(12'h100, 32'h0);
      rd(12'h108, 32'h0);
      $display("ack test done");
      pin(0, 1'b1);
      wr(`ETC_ADDR_CAPEN, 32'hFFFFFFFE);
      ctrl.strobe(32'h1 << `ETC_STRB_CLR);
      rd(`ETC_ADDR_FLAGS, 32'h0);
      rd(`ETC_ADDR_EVCNT, 32'h0);
      rd(12'h100, 32'h0);
      pin(0, 1'b0);
      pin(0, 1'b1);
      rd(12'h100, 32'h0);
      rd(`ETC_ADDR_EVCNT, 32'h1);
      $display("clear test done");
      wr(`ETC_ADDR_CAPEN, 32'hFFFFFFFF);
      wr(`ETC_ADDR_CTRL, 32'h0);
      ctrl.strobe(32'h1 << `ETC_STRB_CLR);
      pin(0, 1'b0);
      get(12'h108);
      a = r;
      pin(0, 1'b1);
      pin(0, 1'b0);
      get(12'h108);
      b = r;
      cmp({31'h0, b > a}, 32'h1);
      rd(`ETC_ADDR_FLAGS, 32'h00010001);
      $display("unlatched test done");
      wr(`ETC_ADDR_CTRL, 32'h3);
      wr(`ETC_ADDR_CAPEN, 32'hFFFFFFFE);
      ctrl.strobe(32'h1 << `ETC_STRB_CLR);
      pin(0, 1'b1);
      rd(`ETC_ADDR_QSTAT, 32'h0);
      pin(2, 1'b1);
      pin(3, 1'b1);
      // Both pins fall together, so two events enter on back-to-back cycles
      @(posedge core_clk_i);
      din[3:2] <= 2'b00;
      repeat (10) @(posedge core_clk_i);
      pin(2, 1'b1);
      rd(`ETC_ADDR_QSTAT, 32'h104);
      rd(`ETC_ADDR_FLAGS, 32'h00040000);
      rd(`ETC_ADDR_HINFO, 32'h00010012);
      rd(`ETC_ADDR_HHI, 32'h0);
      get(`ETC_ADDR_HLO);
      a = r;
      wr(`ETC_ADDR_ECHO, 32'h5);
      rd(`ETC_ADDR_HINFO, 32'h00010012);
      ctrl.pop();
      rd(`ETC_ADDR_HINFO, 32'h00020013);
      get(`ETC_ADDR_HLO);
      cmp({31'h0, r > a}, 32'h1);
      ctrl.pop();
      rd(`ETC_ADDR_HINFO, 32'h00030002);
      rd(`ETC_ADDR_QSTAT, 32'h102);
      ctrl.strobe(32'h1 << `ETC_STRB_CLR);
      rd(`ETC_ADDR_QSTAT, 32'h0);
      $display("queue test done");
      summarize();
   end
endmodule // tb
